// File: pkg/pbr_consts.svh
// constants of the parity ram board bus slave and its bus master
// Operation
// [RULE_01] array by memory commands, flag by I/O
// [RULE_02] port decode matches configurable lines and states
// [RULE_03] port decode width 8, 12 or 16
// [RULE_04] default flag port address is 000FH
// [RULE_05] I/O read returns parity flag register
// [RULE_06] I/O write clears flag, selects parity
// [RULE_07] parity error latches its location
// [RULE_08] command comes 50 ns after address
// [RULE_09] read data stable before acknowledge
// [RULE_10] master captures data, then withdraws read
// [RULE_11] write data stable before write command
// [RULE_12] acknowledge write after store finished
// [RULE_13] master holds data, address 50 ns
// [RULE_14] refresh one row every 15 us
// [RULE_15] external refresh request on falling low
// [RULE_16] external requests only raise refresh rate
// [RULE_17] external request zeroes refresh timer
// [RULE_18] refresh waits at most one access
// [RULE_19] one parity bit per byte stored
// [RULE_20] even parity by default
// [RULE_21] parity bits driven to auxiliary connector
// [RULE_22] memory protect refuses every memory access
// [RULE_23] flag register cleared at reset
// [RULE_24] first error held until I/O write
`ifndef PBR_CONSTS_SVH
`define PBR_CONSTS_SVH

`define PBR_ADR_W        18
`define PBR_DAT_W        16
`define PBR_ROW_W        7
`define PBR_CLK_NS       10
// bus timing
`define PBR_SETUP_NS     50
`define PBR_HOLD_NS      50
`define PBR_SETUP_CYC    ((`PBR_SETUP_NS + `PBR_CLK_NS - 1) / `PBR_CLK_NS)
`define PBR_HOLD_CYC     ((`PBR_HOLD_NS + `PBR_CLK_NS - 1) / `PBR_CLK_NS)
`define PBR_TIMEOUT_CYC  64
// refresh
`define PBR_REF_US       15
`define PBR_REF_CYC      ((`PBR_REF_US * 1000) / `PBR_CLK_NS)
`define PBR_ACC_CYC      4
`define PBR_RFS_CYC      3
// flag port decode
`define PBR_IOW_8        2'h0
`define PBR_IOW_12       2'h1
`define PBR_IOW_16       2'h2
// [RULE_04] default port 000FH
`define PBR_IOW_DEF      2'h2
`define PBR_IOST_DEF     5'h0F
// flag register fields
`define PBR_FLG_VALID    15
`define PBR_FLG_ERR_HI   14
`define PBR_FLG_ERR_LO   13
`define PBR_FLG_RESET    16'h0000
`define PBR_IOW_ODD_BIT  0
// host register offsets
`define PBR_H_ADDR       8'h00
`define PBR_H_WDATA      8'h04
`define PBR_H_CMD        8'h08
`define PBR_H_CTRL       8'h0C
`define PBR_H_STATUS     8'h10
`define PBR_H_RDATA      8'h14
// host command codes
`define PBR_OP_NONE      3'h0
`define PBR_OP_MRD       3'h1
`define PBR_OP_MWR       3'h2
`define PBR_OP_IORD      3'h3
`define PBR_OP_IOWR      3'h4
`define PBR_CMD_REFQ_BIT 4

`endif

// File: pkg/pbr_pkg.sv
// types of the parity ram board bus slave and its bus master
package pbr_pkg;
    typedef enum logic [4:0] {
        PBR_D_IDLE  = 5'h01,
        PBR_D_READ  = 5'h02,
        PBR_D_WRITE = 5'h04,
        PBR_D_IO    = 5'h08,
        PBR_D_RFSH  = 5'h10
    } pbr_dev_state_t;

    typedef enum logic [3:0] {
        PBR_H_IDLE  = 4'h1,
        PBR_H_SETUP = 4'h2,
        PBR_H_CMD   = 4'h4,
        PBR_H_HOLD  = 4'h8
    } pbr_host_state_t;
endpackage : pbr_pkg

// File: pkg/pbr_bus_if.sv
// system bus between the board and its bus master
`timescale 1ns/1ps
`default_nettype none
interface pbr_bus_if;
    logic [17:0] adr_n;
    logic [15:0] host_dat_n;
    logic        host_dat_oe;
    logic [15:0] dev_dat_n;
    logic        dev_dat_oe;
    logic [15:0] dat_n;
    logic        mrdc_n;
    logic        mwtc_n;
    logic        iorc_n;
    logic        iowc_n;
    logic        xack_n;
    logic        ext_refresh_request_n;
    logic        memory_protect_n;
    logic [1:0]  par_bits;

    // pulled-up data lines
    assign dat_n = dev_dat_oe ? dev_dat_n : (host_dat_oe ? host_dat_n : 16'hFFFF);

    modport dev (
        input  adr_n, dat_n, mrdc_n, mwtc_n, iorc_n, iowc_n,
        input  ext_refresh_request_n, memory_protect_n,
        output dev_dat_n, dev_dat_oe, xack_n, par_bits
    );
    modport host (
        output adr_n, host_dat_n, host_dat_oe, mrdc_n, mwtc_n, iorc_n, iowc_n,
        output ext_refresh_request_n, memory_protect_n,
        input  dat_n, xack_n, par_bits
    );
endinterface : pbr_bus_if
`default_nettype wire

// File: src/pbr_device.sv
// parity ram board: bus slave, refresh, parity and flag register
`timescale 1ns/1ps
`default_nettype none
`include "pbr_consts.svh"
module pbr_device
    import pbr_pkg::*;
#(
    parameter int          WORD_AW      = 8,
    parameter logic [8:0]  MEM_BASE     = 9'h000,
    parameter int          ACC_CYCLES   = `PBR_ACC_CYC,
    parameter int          RFS_CYCLES   = `PBR_RFS_CYC,
    parameter int          REF_INTERVAL = `PBR_REF_CYC
) (
    // clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RST,
    // system bus
    pbr_bus_if.dev           bus,
    // flag port configuration
    input  wire logic [1:0]  IO_WIDTH_SEL,
    input  wire logic [4:0]  IO_ADDR_STATE,
    // status
    output logic [15:0]      FLAG_VALUE,
    output logic             ODD_PARITY,
    output logic [6:0]       REFRESH_ROW,
    output logic             REFRESH_ACTIVE
);
    localparam int DEPTH = 1 << WORD_AW;

    pbr_dev_state_t  state_reg;
    logic [7:0]      cnt_reg;
    logic [15:0]     mem [DEPTH];
    logic [1:0]      par_mem [DEPTH];
    logic [15:0]     rdata_reg;
    logic            drive_reg;
    logic            ack_reg;
    logic [15:0]     flag_reg;
    logic            odd_reg;
    logic [1:0]      par_out_reg;
    logic [6:0]      row_reg;
    logic [15:0]     tmr_reg;
    logic            pend_reg;
    logic            ext_q_reg;

    logic [17:0]     a;
    logic [15:0]     d_in;
    logic [WORD_AW-1:0] idx;
    logic            mem_sel;
    logic            io_sel;
    logic            protect;
    logic            mem_rd;
    logic            mem_wr;
    logic            io_rd;
    logic            io_wr;
    logic            no_cmd;
    logic            ext_fall;
    logic            tmr_wrap;
    logic            start_rfsh;
    logic            acc_done;
    logic            rfs_done;
    logic [1:0]      par_calc;
    logic [1:0]      par_rd;

    // even parity is the xor of the byte, odd its complement
    function automatic logic [1:0] byte_parity(input logic [15:0] w, input logic odd);
        byte_parity = {^w[15:8] ^ odd, ^w[7:0] ^ odd};
    endfunction

    // flag port decode over the selected address width
    function automatic logic io_match(input logic [15:0] ad, input logic [1:0] wsel,
                                      input logic [4:0] st);
        logic ok;
        ok = (ad[0] == st[0]) && (ad[1] == st[1]) && (ad[2] == st[2]) &&
             (ad[3] == st[3]) && (ad[6] == st[4]) && !ad[4] && !ad[5] && !ad[7];
        if (wsel != `PBR_IOW_8) begin
            ok = ok && (ad[11:8] == 4'h0);
        end
        if (wsel == `PBR_IOW_16) begin
            ok = ok && (ad[15:12] == 4'h0);
        end
        io_match = ok;
    endfunction

    assign a        = ~bus.adr_n;
    assign d_in     = ~bus.dat_n;
    assign idx      = a[WORD_AW:1];
    assign mem_sel  = (a[17:WORD_AW+1] == MEM_BASE[16-WORD_AW:0]);
    // [RULE_02] flag port compare
    // [RULE_03] decode width select
    assign io_sel   = io_match(a[15:0], IO_WIDTH_SEL, IO_ADDR_STATE);
    assign protect  = ~bus.memory_protect_n;
    // [RULE_01] memory commands to array
    assign mem_rd   = ~bus.mrdc_n & mem_sel;
    assign mem_wr   = ~bus.mwtc_n & mem_sel;
    // [RULE_01] I/O commands to flag
    assign io_rd    = ~bus.iorc_n & io_sel;
    assign io_wr    = ~bus.iowc_n & io_sel;
    assign no_cmd   = bus.mrdc_n & bus.mwtc_n & bus.iorc_n & bus.iowc_n;
    // [RULE_15] falling request edge
    assign ext_fall = ext_q_reg & ~bus.ext_refresh_request_n;
    assign tmr_wrap = (tmr_reg == 16'(REF_INTERVAL - 1));
    assign start_rfsh = (state_reg == PBR_D_IDLE) && pend_reg;
    assign acc_done = (cnt_reg == 8'(ACC_CYCLES - 1));
    assign rfs_done = (cnt_reg == 8'(RFS_CYCLES - 1));
    assign par_calc = byte_parity(d_in, odd_reg);
    assign par_rd   = byte_parity(mem[idx], odd_reg);

    // controller sequencing
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            state_reg <= PBR_D_IDLE;
            cnt_reg   <= 8'h00;
        end else begin
            unique case (state_reg)
                PBR_D_IDLE: begin
                    cnt_reg <= 8'h00;
                    // [RULE_18] refresh before next access
                    if (pend_reg) begin
                        state_reg <= PBR_D_RFSH;
                    end else if (!ack_reg) begin
                        // [RULE_22] protect refuses memory
                        if (mem_rd && !protect) begin
                            state_reg <= PBR_D_READ;
                        end else if (mem_wr && !protect) begin
                            state_reg <= PBR_D_WRITE;
                        end else if (io_rd || io_wr) begin
                            state_reg <= PBR_D_IO;
                        end
                    end
                end
                PBR_D_READ, PBR_D_WRITE: begin
                    cnt_reg <= cnt_reg + 8'h01;
                    if (acc_done) begin
                        state_reg <= PBR_D_IDLE;
                    end
                end
                PBR_D_IO: begin
                    state_reg <= PBR_D_IDLE;
                end
                PBR_D_RFSH: begin
                    cnt_reg <= cnt_reg + 8'h01;
                    if (rfs_done) begin
                        state_reg <= PBR_D_IDLE;
                    end
                end
            endcase
        end
    end

    // array and parity storage
    always_ff @(posedge REF_CLK) begin
        // [RULE_12] store then acknowledge
        // [RULE_19] per-byte parity stored
        if (state_reg == PBR_D_WRITE && acc_done) begin
            mem[idx]     <= d_in;
            par_mem[idx] <= par_calc;
        end
    end

    // read data and bus drive
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            rdata_reg <= 16'h0000;
            drive_reg <= 1'b0;
        end else begin
            if (state_reg == PBR_D_READ && acc_done) begin
                rdata_reg <= mem[idx];
                drive_reg <= 1'b1;
            end else if (state_reg == PBR_D_IO && io_rd) begin
                // [RULE_05] flag register readback
                rdata_reg <= flag_reg;
                drive_reg <= 1'b1;
            end else if (no_cmd) begin
                drive_reg <= 1'b0;
            end
        end
    end

    // transfer acknowledge, held until command withdrawn
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            ack_reg <= 1'b0;
        end else begin
            // [RULE_09] acknowledge set on the same edge that latches the data
            if ((state_reg == PBR_D_READ || state_reg == PBR_D_WRITE) && acc_done) begin
                ack_reg <= 1'b1;
            end else if (state_reg == PBR_D_IO) begin
                ack_reg <= 1'b1;
            end else if (no_cmd) begin
                ack_reg <= 1'b0;
            end
        end
    end

    // parity flag register and parity type
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            // [RULE_23] cleared at reset
            // [RULE_20] even parity default
            flag_reg <= `PBR_FLG_RESET;
            odd_reg  <= 1'b0;
        end else begin
            if (state_reg == PBR_D_IO && io_wr) begin
                // [RULE_06] clear and parity select
                flag_reg <= `PBR_FLG_RESET;
                odd_reg  <= d_in[`PBR_IOW_ODD_BIT];
            end else if (state_reg == PBR_D_READ && acc_done &&
                         par_rd != par_mem[idx] && !flag_reg[`PBR_FLG_VALID]) begin
                // [RULE_07] latch error location
                // [RULE_24] first error kept
                flag_reg <= 16'h0000;
                flag_reg[`PBR_FLG_VALID]  <= 1'b1;
                flag_reg[`PBR_FLG_ERR_HI] <= par_rd[1] ^ par_mem[idx][1];
                flag_reg[`PBR_FLG_ERR_LO] <= par_rd[0] ^ par_mem[idx][0];
                flag_reg[WORD_AW-1:0]     <= idx;
            end
        end
    end

    // parity bits on the auxiliary connector
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            par_out_reg <= 2'h0;
        end else if (acc_done) begin
            // [RULE_21] parity to connector
            if (state_reg == PBR_D_READ) begin
                par_out_reg <= par_mem[idx];
            end else if (state_reg == PBR_D_WRITE) begin
                par_out_reg <= par_calc;
            end
        end
    end

    // refresh timer, request and row counter
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            tmr_reg   <= 16'h0000;
            pend_reg  <= 1'b0;
            row_reg   <= 7'h00;
            ext_q_reg <= 1'b1;
        end else begin
            ext_q_reg <= bus.ext_refresh_request_n;
            // [RULE_17] external request zeroes timer
            // [RULE_14] internal interval wrap
            if (ext_fall || tmr_wrap) begin
                tmr_reg <= 16'h0000;
            end else begin
                tmr_reg <= tmr_reg + 16'h0001;
            end
            // [RULE_16] either source requests refresh
            if (ext_fall || tmr_wrap) begin
                pend_reg <= 1'b1;
            end else if (start_rfsh) begin
                pend_reg <= 1'b0;
            end
            // [RULE_14] refresh row advances
            if (state_reg == PBR_D_RFSH && rfs_done) begin
                row_reg <= row_reg + 7'h01;
            end
        end
    end

    assign bus.dev_dat_n  = ~rdata_reg;
    assign bus.dev_dat_oe = drive_reg & (~bus.mrdc_n | ~bus.iorc_n);
    assign bus.xack_n     = ~ack_reg;
    assign bus.par_bits   = par_out_reg;
    assign FLAG_VALUE     = flag_reg;
    assign ODD_PARITY     = odd_reg;
    assign REFRESH_ROW    = row_reg;
    assign REFRESH_ACTIVE = (state_reg == PBR_D_RFSH);
endmodule // pbr_device
`default_nettype wire

// File: src/pbr_host.sv
// bus master end: issues memory and I/O commands from its registers
`timescale 1ns/1ps
`default_nettype none
`include "pbr_consts.svh"
module pbr_host
    import pbr_pkg::*;
#(
    parameter int SETUP_CYCLES   = `PBR_SETUP_CYC,
    parameter int HOLD_CYCLES    = `PBR_HOLD_CYC,
    parameter int TIMEOUT_CYCLES = `PBR_TIMEOUT_CYC
) (
    // clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RST,
    // register port
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [31:0] REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic [31:0]      REG_RDATA,
    // system bus
    pbr_bus_if.host          bus
);
    pbr_host_state_t state_reg;
    logic [7:0]      cnt_reg;
    logic [17:0]     addr_reg;
    logic [15:0]     wdata_reg;
    logic [15:0]     rdata_reg;
    logic [1:0]      par_reg;
    logic [2:0]      op_reg;
    logic            protect_reg;
    logic            refq_reg;
    logic            timeout_reg;
    logic            done_reg;
    logic            is_write;
    logic            start;
    logic            xack_seen;
    logic            timed_out;

    assign start     = REG_WR && REG_ADDR == `PBR_H_CMD && state_reg == PBR_H_IDLE &&
                       REG_WDATA[2:0] != `PBR_OP_NONE;
    assign is_write  = (op_reg == `PBR_OP_MWR) || (op_reg == `PBR_OP_IOWR);
    assign xack_seen = (state_reg == PBR_H_CMD) && !bus.xack_n;
    assign timed_out = (state_reg == PBR_H_CMD) && bus.xack_n &&
                       (cnt_reg == 8'(TIMEOUT_CYCLES - 1));

    // software registers
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            addr_reg    <= 18'h00000;
            wdata_reg   <= 16'h0000;
            protect_reg <= 1'b0;
            refq_reg    <= 1'b0;
        end else begin
            refq_reg <= 1'b0;
            if (REG_WR && state_reg == PBR_H_IDLE) begin
                if (REG_ADDR == `PBR_H_ADDR) begin
                    addr_reg <= REG_WDATA[17:0];
                end
                if (REG_ADDR == `PBR_H_WDATA) begin
                    wdata_reg <= REG_WDATA[15:0];
                end
            end
            if (REG_WR && REG_ADDR == `PBR_H_CTRL) begin
                protect_reg <= REG_WDATA[0];
            end
            if (REG_WR && REG_ADDR == `PBR_H_CMD) begin
                refq_reg <= REG_WDATA[`PBR_CMD_REFQ_BIT];
            end
        end
    end

    // bus cycle sequencing
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            state_reg <= PBR_H_IDLE;
            cnt_reg   <= 8'h00;
            op_reg    <= `PBR_OP_NONE;
        end else begin
            unique case (state_reg)
                PBR_H_IDLE: begin
                    cnt_reg <= 8'h00;
                    if (start) begin
                        op_reg    <= REG_WDATA[2:0];
                        state_reg <= PBR_H_SETUP;
                    end
                end
                PBR_H_SETUP: begin
                    // [RULE_08] address setup before command
                    // [RULE_11] write data settled first
                    cnt_reg <= cnt_reg + 8'h01;
                    if (cnt_reg == 8'(SETUP_CYCLES - 1)) begin
                        cnt_reg   <= 8'h00;
                        state_reg <= PBR_H_CMD;
                    end
                end
                PBR_H_CMD: begin
                    cnt_reg <= cnt_reg + 8'h01;
                    if (xack_seen || timed_out) begin
                        cnt_reg   <= 8'h00;
                        state_reg <= PBR_H_HOLD;
                    end
                end
                PBR_H_HOLD: begin
                    // [RULE_13] hold address and data
                    cnt_reg <= cnt_reg + 8'h01;
                    if (cnt_reg == 8'(HOLD_CYCLES - 1)) begin
                        state_reg <= PBR_H_IDLE;
                        op_reg    <= `PBR_OP_NONE;
                    end
                end
            endcase
        end
    end

    // captured answer and sticky status
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            rdata_reg   <= 16'h0000;
            par_reg     <= 2'h0;
            timeout_reg <= 1'b0;
            done_reg    <= 1'b0;
        end else begin
            // [RULE_10] capture before withdrawing
            if (xack_seen && !is_write) begin
                rdata_reg <= ~bus.dat_n;
                par_reg   <= bus.par_bits;
            end
            if (timed_out) begin
                timeout_reg <= 1'b1;
            end else if (REG_WR && REG_ADDR == `PBR_H_STATUS && REG_WDATA[1]) begin
                timeout_reg <= 1'b0;
            end
            if (xack_seen) begin
                done_reg <= 1'b1;
            end else if (REG_WR && REG_ADDR == `PBR_H_STATUS && REG_WDATA[2]) begin
                done_reg <= 1'b0;
            end
        end
    end

    // read data one cycle after the strobe
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            REG_RDATA <= 32'h00000000;
        end else if (REG_RD) begin
            unique case (REG_ADDR)
                `PBR_H_ADDR:   REG_RDATA <= {14'h0000, addr_reg};
                `PBR_H_WDATA:  REG_RDATA <= {16'h0000, wdata_reg};
                `PBR_H_CTRL:   REG_RDATA <= {31'h00000000, protect_reg};
                `PBR_H_STATUS: REG_RDATA <= {26'h0000000, par_reg, 1'b0,
                                             done_reg, timeout_reg, state_reg != PBR_H_IDLE};
                `PBR_H_RDATA:  REG_RDATA <= {16'h0000, rdata_reg};
                default:       REG_RDATA <= 32'h00000000;
            endcase
        end else begin
            REG_RDATA <= 32'h00000000;
        end
    end

    assign bus.adr_n       = (state_reg == PBR_H_IDLE) ? 18'h3FFFF : ~addr_reg;
    assign bus.host_dat_n  = ~wdata_reg;
    assign bus.host_dat_oe = is_write && state_reg != PBR_H_IDLE;
    assign bus.mrdc_n      = !(state_reg == PBR_H_CMD && op_reg == `PBR_OP_MRD);
    assign bus.mwtc_n      = !(state_reg == PBR_H_CMD && op_reg == `PBR_OP_MWR);
    assign bus.iorc_n      = !(state_reg == PBR_H_CMD && op_reg == `PBR_OP_IORD);
    assign bus.iowc_n      = !(state_reg == PBR_H_CMD && op_reg == `PBR_OP_IOWR);
    assign bus.ext_refresh_request_n = ~refq_reg;
    assign bus.memory_protect_n      = ~protect_reg;
endmodule // pbr_host
`default_nettype wire

// File: tb/pbr_sva.sv
// assertions on the system bus between the board and its master
`timescale 1ns/1ps
`default_nettype none
module pbr_sva (
    // clock and reset
    input wire logic        REF_CLK,
    input wire logic        RST,
    // bus lines
    input wire logic [17:0] adr_n,
    input wire logic [15:0] dat_n,
    input wire logic        mrdc_n,
    input wire logic        mwtc_n,
    input wire logic        iorc_n,
    input wire logic        iowc_n,
    input wire logic        xack_n,
    input wire logic        memory_protect_n,
    input wire logic        dev_dat_oe
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);
    wire logic idle = mrdc_n & mwtc_n & iorc_n & iowc_n;

    chk_addr_setup: assert property (($fell(mrdc_n) || $fell(mwtc_n))
        |-> $past(adr_n, 5) == adr_n) else $error("address moved in setup");
    chk_wdata_setup: assert property ($fell(mwtc_n)
        |-> $past(dat_n, 5) == dat_n) else $error("write data moved in setup");
    chk_rdata_drive: assert property (!xack_n && !mrdc_n |-> dev_dat_oe)
        else $error("read acknowledged without data");
    chk_read_release: assert property ($fell(xack_n) && !mrdc_n
        |-> ##[1:2] mrdc_n) else $error("read command not withdrawn");
    chk_write_hold: assert property ($rose(mwtc_n)
        |-> ($stable(adr_n) && $stable(dat_n)) [*5]) else $error("write hold too short");
    chk_mem_ack_time: assert property (($fell(mrdc_n) || $fell(mwtc_n))
        && memory_protect_n |-> xack_n [*5] ##[1:5] !xack_n) else $error("ack timing");
    chk_protect_block: assert property (!memory_protect_n
        && !(mrdc_n && mwtc_n) |-> xack_n) else $error("access under protect");
    chk_ack_release: assert property (!xack_n && idle |=> xack_n)
        else $error("ack held after command");
    chk_ack_cause: assert property ($fell(xack_n) |-> !idle)
        else $error("ack without command");
endmodule // pbr_sva
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench: board and bus master face to face
`timescale 1ns/1ps
`default_nettype none
`include "pbr_consts.svh"
module testbench;
    localparam int RI = 40;
    logic        REF_CLK = 1'b0;
    logic        RST = 1'b1;
    logic [7:0]  REG_ADDR = 8'h00;
    logic [31:0] REG_WDATA = 32'h0;
    logic        REG_WR = 1'b0;
    logic        REG_RD = 1'b0;
    logic [31:0] REG_RDATA;
    logic [1:0]  IO_WIDTH_SEL = `PBR_IOW_DEF;
    logic [4:0]  IO_ADDR_STATE = `PBR_IOST_DEF;
    logic [15:0] FLAG_VALUE;
    logic        ODD_PARITY;
    logic        REFRESH_ACTIVE;
    logic [6:0]  REFRESH_ROW;
    logic [31:0] st;
    logic [31:0] rd;
    logic [15:0] mem [int];
    int          n_mismatch = 0;
    int          checked = 0;
    int          gap = 0;
    int          max_gap = 0;
    int          a;
    pbr_bus_if bus ();
    pbr_device #(.REF_INTERVAL(RI)) u_pbr_device (.REF_CLK(REF_CLK), .RST(RST), .bus(bus.dev),
        .IO_WIDTH_SEL(IO_WIDTH_SEL), .IO_ADDR_STATE(IO_ADDR_STATE), .FLAG_VALUE(FLAG_VALUE),
        .ODD_PARITY(ODD_PARITY), .REFRESH_ROW(REFRESH_ROW), .REFRESH_ACTIVE(REFRESH_ACTIVE));
    pbr_host #(.TIMEOUT_CYCLES(16)) u_pbr_host (.REF_CLK(REF_CLK), .RST(RST),
        .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_RDATA(REG_RDATA), .bus(bus.host));
    pbr_sva u_pbr_sva (.REF_CLK(REF_CLK), .RST(RST), .adr_n(bus.adr_n), .dat_n(bus.dat_n),
        .mrdc_n(bus.mrdc_n), .mwtc_n(bus.mwtc_n), .iorc_n(bus.iorc_n), .iowc_n(bus.iowc_n),
        .xack_n(bus.xack_n), .memory_protect_n(bus.memory_protect_n),
        .dev_dat_oe(bus.dev_dat_oe));
    always #5 REF_CLK = ~REF_CLK;
    // longest stretch without refresh
    always @(posedge REF_CLK) begin
        gap <= (REFRESH_ACTIVE || RST) ? 0 : gap + 1;
        if (gap > max_gap) max_gap <= gap;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
        @(posedge REF_CLK);
        REG_ADDR <= ad;
        REG_WDATA <= wd;
        REG_WR <= 1'b1;
        @(posedge REF_CLK);
        REG_WR <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] ad, output logic [31:0] q);
        @(posedge REF_CLK);
        REG_ADDR <= ad;
        REG_RD <= 1'b1;
        @(posedge REF_CLK);
        REG_RD <= 1'b0;
        #1 q = REG_RDATA;
    endtask
    // one bus command, wait for idle, fetch status and read data
    task automatic go(input logic [2:0] op, input logic [17:0] ad, input logic [15:0] wd);
        wr(`PBR_H_STATUS, 32'h6);
        wr(`PBR_H_ADDR, {14'h0, ad});
        wr(`PBR_H_WDATA, {16'h0, wd});
        wr(`PBR_H_CMD, {29'h0, op});
        for (int i = 0; i < 60 && st[0] !== 1'b0; i++) rdr(`PBR_H_STATUS, st);
        if (st[0] !== 1'b0) begin
            n_mismatch++;
            stop_test();
        end
        rdr(`PBR_H_RDATA, rd);
        st[0] = 1'b1;
    endtask
    task automatic mw(input int ix, input logic [15:0] wd);
        go(`PBR_OP_MWR, 18'(ix * 2), wd);
        mem[ix] = wd;
        chk("par_bits", {30'h0, bus.par_bits}, {30'h0, ^wd[15:8], ^wd[7:0]});
    endtask
    task automatic mr(input int ix);
        go(`PBR_OP_MRD, 18'(ix * 2), 16'h0);
        chk("read_data", rd, {16'h0, mem[ix]});
    endtask
    task automatic io(input int w, input logic [17:0] ad, input logic exp);
        @(posedge REF_CLK) IO_WIDTH_SEL <= 2'(w);
        go(`PBR_OP_IORD, ad, 16'h0);
        chk("io_refused", st[1], exp);
    endtask
    initial begin
        st = 32'h1;
        a = $urandom(32'h27C27F66);
        repeat (5) @(posedge REF_CLK);
        RST <= 1'b0;
        #1;
        chk("flag_reset", FLAG_VALUE, 16'h0);
        chk("odd_reset", ODD_PARITY, 1'b0);
        mw(0, 16'hFFFF);
        mw(255, 16'h0001);
        for (int i = 0; i < 6; i++) mw($urandom % 256, 16'($urandom));
        go(`PBR_OP_IORD, 18'h0000F, 16'h0);
        chk("flag_read", rd, 32'h0);
        chk("flag_port", st[1], 1'b0);
        io(2, 18'h0001F, 1'b1);
        for (int w = 0; w < 3; w++) begin
            io(w, 18'h0100F, w == 2);
            io(w, 18'h0010F, w >= 1);
        end
        @(posedge REF_CLK) IO_ADDR_STATE <= 5'h11;
        io(2, 18'h00041, 1'b0);
        @(posedge REF_CLK) IO_ADDR_STATE <= `PBR_IOST_DEF;
        // odd mode turns stored even parity into an error
        go(`PBR_OP_IOWR, 18'h0000F, 16'h0001);
        chk("odd_sel", ODD_PARITY, 1'b1);
        mr(0);
        mr(255);
        go(`PBR_OP_IORD, 18'h0000F, 16'h0);
        chk("flag_first", rd, 32'h0000E000);
        go(`PBR_OP_IOWR, 18'h0000F, 16'h0000);
        chk("flag_clear", {FLAG_VALUE, 15'h0, ODD_PARITY}, 32'h0);
        wr(`PBR_H_CTRL, 32'h1);
        go(`PBR_OP_MWR, 18'h0, 16'h5A5A);
        chk("protect", st[1], 1'b1);
        wr(`PBR_H_CTRL, 32'h0);
        foreach (mem[k]) mr(k);
        // begin right after an internal refresh
        for (a = 0; a < 60 && REFRESH_ACTIVE !== 1'b1; a++) #10;
        for (a = 0; a < 9 && REFRESH_ACTIVE !== 1'b0; a++) #10;
        rd = {25'h0, REFRESH_ROW};
        wr(`PBR_H_CMD, 32'h10);
        #1;
        for (a = 0; a < 10 && REFRESH_ACTIVE !== 1'b1; a++) #10;
        chk("ext_refresh", a < 10, 1'b1);
        for (a = 0; a < 60 && REFRESH_ACTIVE !== 1'b0; a++) #10;
        chk("refresh_row", REFRESH_ROW, 7'(rd + 1));
        for (a = 0; a < 60 && REFRESH_ACTIVE !== 1'b1; a++) #10;
        chk("timer_zeroed", a >= RI - 8 && a <= RI, 1'b1);
        chk("refresh_gap", max_gap <= RI + 6, 1'b1);
        stop_test();
    end
endmodule // testbench
`default_nettype wire
